// ### dic_regs.svh
// register offsets, field positions, reset values and timing counts of the config block
`ifndef DIC_REGS_SVH
`define DIC_REGS_SVH
`define DIC_SEL_BASE 2'h0
`define DIC_SEL_EXT1 2'h1
`define DIC_SEL_EXT2 2'h2
`define DIC_SEL_EXT3 2'h3
`define DIC_CFG_RST 13'h0000
`define DIC_BL_LSB 0
`define DIC_BL_MSB 2
`define DIC_BT_BIT 3
`define DIC_CL_LSB 4
`define DIC_CL_MSB 6
`define DIC_TM_BIT 7
`define DIC_DLLRST_BIT 8
`define DIC_WR_LSB 9
`define DIC_WR_MSB 11
`define DIC_DLLDIS_BIT 0
`define DIC_RDS_BIT 1
`define DIC_RTT0_BIT 2
`define DIC_ADDLAT_LSB 3
`define DIC_ADDLAT_MSB 5
`define DIC_RTT1_BIT 6
`define DIC_CAL_LSB 7
`define DIC_CAL_MSB 9
`define DIC_NDQS_BIT 10
`define DIC_SRT_BIT 7
`define DIC_BL4 3'h2
`define DIC_BL8 3'h3
`define DIC_DLL_LOCK_CLKS 8'hc8
`define DIC_CNT_ZERO 8'h00
`define DIC_CNT_ONE 8'h01
`endif

// ### dic_pkg.sv
// types shared by the config block
package dic_pkg;
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [1:0] bank_sel;
      logic [12:0] addr;
   } dic_cmd_t;
   typedef struct packed {
      logic [2:0] burst_len;
      logic burst_interleave;
      logic [2:0] read_latency;
      logic test_mode;
      logic [2:0] write_recovery;
      logic dll_enabled;
      logic reduced_drive;
      logic [2:0] added_latency;
      logic [1:0] termination_value;
      logic [2:0] driver_calibration;
      logic strobe_compl_off;
      logic fast_self_refresh;
      logic burst_len_legal;
   } dic_cfg_t;
endpackage

// ### dic_dll_timer.sv
// dll lock counter: counts sampled clocks after a dll reset
`include "dic_regs.svh"
module dic_dll_timer (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic restart,
   input wire logic tick,
   output logic locked
);
   logic [7:0] cnt_reg;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= `DIC_CNT_ZERO;
      end else if (restart) begin
         cnt_reg <= `DIC_DLL_LOCK_CLKS;
      end else if (tick && cnt_reg != `DIC_CNT_ZERO) begin
         cnt_reg <= cnt_reg - `DIC_CNT_ONE;
      end
   end
   assign locked = (cnt_reg == `DIC_CNT_ZERO);
endmodule

// ### dic_core.sv
// config register block of the dram: command decode and base/extended config storage
// Operation
// - config writes leave array contents intact
// - all strobes low decode a config write
// - config registers undefined until programmed
// - burst length 4 or 8, ordering bit
// - read latency, test mode, dll reset bits
// - write recovery cycles in bits 11..9
// - ext config 1 field layout
// - dll off in self refresh, reset on exit
// - chip select high masks all commands
// - inputs sampled on rising clock edge
`include "dic_regs.svh"
module dic_core
   import dic_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input dic_pkg::dic_cmd_t cmd_pins,
   input wire logic clk_en_pin,
   input wire logic self_refresh_enter,
   input wire logic self_refresh_exit,
   output dic_pkg::dic_cfg_t cfg,
   output logic [3:0] programmed,
   output logic dll_reset_pulse,
   output logic dll_locked,
   output logic read_ready
);
   import dic_pkg::*;

   // ************************************************
   // reset release and pin synchronisers
   // ************************************************
   logic rst_s1_reg, rst_n;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rst_s1_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n <= rst_s1_reg;
      end
   end

   // pins come from the controller's clock; two stages before any decode
   dic_cmd_t cmd_s1_reg, cmd_reg;
   logic cke_s1_reg, cke_reg, sre_s1_reg, sre_reg, srx_s1_reg, srx_reg;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cmd_s1_reg <= '1;
         cmd_reg <= '1;
         cke_s1_reg <= 1'b0;
         cke_reg <= 1'b0;
         sre_s1_reg <= 1'b0;
         sre_reg <= 1'b0;
         srx_s1_reg <= 1'b0;
         srx_reg <= 1'b0;
      end else begin
         cmd_s1_reg <= cmd_pins;
         cmd_reg <= cmd_s1_reg;
         cke_s1_reg <= clk_en_pin;
         cke_reg <= cke_s1_reg;
         sre_s1_reg <= self_refresh_enter;
         sre_reg <= sre_s1_reg;
         srx_s1_reg <= self_refresh_exit;
         srx_reg <= srx_s1_reg;
      end
   end

   // ************************************************
   // command decode
   // ************************************************
   logic cfg_write;
   // chip select is part of the code, so a high select masks everything
   assign cfg_write = cke_reg && !cmd_reg.cs_n && !cmd_reg.ras_n && !cmd_reg.cas_n
                      && !cmd_reg.we_n;

   // ************************************************
   // config register storage
   // ************************************************
   // contents are undefined after power-up; zero here, flagged by programmed
   logic [12:0] cfg_reg [4];
   logic [3:0] prog_reg;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_cfg
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               cfg_reg[gi] <= `DIC_CFG_RST;
               prog_reg[gi] <= 1'b0;
            end else if (cfg_write && cmd_reg.bank_sel == 2'(gi)) begin
               // the whole word is replaced, no field merging
               cfg_reg[gi] <= cmd_reg.addr;
               prog_reg[gi] <= 1'b1;
            end
         end
      end
   endgenerate
   // array storage is not touched by anything here

   // ************************************************
   // dll state
   // ************************************************
   logic dll_rst_cmd, in_sr_reg, dll_rst_reg;
   assign dll_rst_cmd = cfg_write && cmd_reg.bank_sel == `DIC_SEL_BASE
                        && cmd_reg.addr[`DIC_DLLRST_BIT];
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         in_sr_reg <= 1'b0;
      end else if (sre_reg) begin
         in_sr_reg <= 1'b1;
      end else if (srx_reg) begin
         in_sr_reg <= 1'b0;
      end
   end
   logic dll_restart;
   // self refresh exit resets the dll just as a reset command does
   assign dll_restart = dll_rst_cmd || (srx_reg && in_sr_reg);
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dll_rst_reg <= 1'b0;
      end else begin
         dll_rst_reg <= dll_restart;
      end
   end
   logic lock_w;
   dic_dll_timer dic_dll_timer_inst (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .restart(dll_restart),
      .tick(cke_reg),
      .locked(lock_w)
   );

   // ************************************************
   // decoded outputs
   // ************************************************
   dic_cfg_t cfg_next;
   always_comb begin
      cfg_next.burst_len = cfg_reg[`DIC_SEL_BASE][`DIC_BL_MSB:`DIC_BL_LSB];
      cfg_next.burst_interleave = cfg_reg[`DIC_SEL_BASE][`DIC_BT_BIT];
      cfg_next.read_latency = cfg_reg[`DIC_SEL_BASE][`DIC_CL_MSB:`DIC_CL_LSB];
      cfg_next.test_mode = cfg_reg[`DIC_SEL_BASE][`DIC_TM_BIT];
      cfg_next.write_recovery = cfg_reg[`DIC_SEL_BASE][`DIC_WR_MSB:`DIC_WR_LSB];
      cfg_next.dll_enabled = !cfg_reg[`DIC_SEL_EXT1][`DIC_DLLDIS_BIT] && !in_sr_reg;
      cfg_next.reduced_drive = cfg_reg[`DIC_SEL_EXT1][`DIC_RDS_BIT];
      cfg_next.added_latency = cfg_reg[`DIC_SEL_EXT1][`DIC_ADDLAT_MSB:`DIC_ADDLAT_LSB];
      cfg_next.termination_value = {cfg_reg[`DIC_SEL_EXT1][`DIC_RTT1_BIT],
                                    cfg_reg[`DIC_SEL_EXT1][`DIC_RTT0_BIT]};
      cfg_next.driver_calibration = cfg_reg[`DIC_SEL_EXT1][`DIC_CAL_MSB:`DIC_CAL_LSB];
      cfg_next.strobe_compl_off = cfg_reg[`DIC_SEL_EXT1][`DIC_NDQS_BIT];
      cfg_next.fast_self_refresh = cfg_reg[`DIC_SEL_EXT2][`DIC_SRT_BIT];
      cfg_next.burst_len_legal = cfg_next.burst_len == `DIC_BL4
                                 || cfg_next.burst_len == `DIC_BL8;
   end
   // ext config 3 contents drive nothing; only its programmed flag feeds programmed and read_ready

   logic rdy_next;
   assign rdy_next = lock_w && cfg_next.dll_enabled && (&prog_reg);
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg <= '0;
         programmed <= 4'h0;
         dll_reset_pulse <= 1'b0;
         dll_locked <= 1'b0;
         read_ready <= 1'b0;
      end else begin
         cfg <= cfg_next;
         programmed <= prog_reg;
         dll_reset_pulse <= dll_rst_reg;
         dll_locked <= lock_w;
         read_ready <= rdy_next;
      end
   end

   // ************************************************
   // checks
   // ************************************************
   property p_cs_masks;
      @(posedge clk_sys) disable iff (!rst_n)
      cmd_reg.cs_n |=> $stable(prog_reg) && $stable(cfg_reg[0]) && $stable(cfg_reg[1]);
   endproperty
   a_cs_masks: assert property (p_cs_masks) else $error("write taken with select high");
   property p_latch;
      @(posedge clk_sys) disable iff (!rst_n)
      cfg_write |=> cfg_reg[$past(cmd_reg.bank_sel)] == $past(cmd_reg.addr);
   endproperty
   a_latch: assert property (p_latch) else $error("address not latched");
   property p_other_kept;
      @(posedge clk_sys) disable iff (!rst_n)
      (cfg_write && cmd_reg.bank_sel != `DIC_SEL_EXT3) |=> $stable(cfg_reg[3]);
   endproperty
   a_other_kept: assert property (p_other_kept) else $error("unselected register changed");
   property p_no_write;
      @(posedge clk_sys) disable iff (!rst_n)
      !cfg_write |=> $stable(cfg_reg[0]);
   endproperty
   a_no_write: assert property (p_no_write) else $error("base changed without write");
   property p_dll_unlock;
      @(posedge clk_sys) disable iff (!rst_n)
      dll_restart |=> !lock_w ##1 !dll_locked;
   endproperty
   a_dll_unlock: assert property (p_dll_unlock) else $error("lock not dropped");
   property p_pulse;
      @(posedge clk_sys) disable iff (!rst_n)
      dll_rst_cmd |-> ##2 dll_reset_pulse;
   endproperty
   a_pulse: assert property (p_pulse) else $error("reset pulse missing");
   property p_sr_dll;
      @(posedge clk_sys) disable iff (!rst_n)
      in_sr_reg |=> !cfg.dll_enabled;
   endproperty
   a_sr_dll: assert property (p_sr_dll) else $error("dll on in self refresh");
   property p_ready;
      @(posedge clk_sys) disable iff (!rst_n)
      read_ready |-> dll_locked && (&programmed);
   endproperty
   a_ready: assert property (p_ready) else $error("ready before lock");
   property p_legal;
      @(posedge clk_sys) disable iff (!rst_n)
      cfg.burst_len_legal == (cfg.burst_len == `DIC_BL4 || cfg.burst_len == `DIC_BL8);
   endproperty
   a_legal: assert property (p_legal) else $error("burst flag wrong");
   c_write: cover property (@(posedge clk_sys) disable iff (!rst_n) cfg_write);
   c_all: cover property (@(posedge clk_sys) disable iff (!rst_n) &prog_reg);
   c_ready: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(read_ready));
endmodule

// ### dic_ctrl_model.sv
// controller model that drives the command pins and clock enable of the config block
module dic_ctrl_model
   import dic_pkg::*;
(
   input wire logic clk_sys,
   output dic_pkg::dic_cmd_t cmd_pins,
   output logic clk_en_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cmd_pins = '1;
      clk_en_pin = 1'b0;
   end
   // deselect: lines other than chip select flip, so no stale value looks held
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         cmd_pins <= {1'b1, ~cmd_pins[17:0]};
      end
   endtask
   task automatic issue(input logic [3:0] code, input logic [1:0] bs, input logic [12:0] a);
      @(posedge clk_sys);
      cmd_pins <= {code, bs, a};
      idle(3);
   endtask
   task automatic set_cke(input logic v);
      @(posedge clk_sys);
      clk_en_pin <= v;
      idle(4);
   endtask
   task automatic power_up();
      idle(25000);
      set_cke(1'b1);
      idle(50);
   endtask
endmodule

// ### tb_dic_core.sv
// self-checking bench for the dram config block
`include "dic_regs.svh"
module tb_dic_core;
   timeunit 1ns;
   timeprecision 1ps;
   import dic_pkg::*;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic self_refresh_enter = 1'b0;
   logic self_refresh_exit = 1'b0;
   dic_cmd_t cmd_pins;
   logic clk_en_pin;
   dic_cfg_t cfg;
   logic [3:0] programmed;
   logic dll_reset_pulse, dll_locked, read_ready;
   int error_cnt = 0;
   int comparisons = 0;
   int pulses = 0;
   int cyc = 0;
   always #4 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (dll_reset_pulse === 1'b1)
         pulses <= pulses + 1;
   end
   dic_core dic_core_inst (.clk_sys(clk_sys), .nrst(nrst), .cmd_pins(cmd_pins),
      .clk_en_pin(clk_en_pin), .self_refresh_enter(self_refresh_enter),
      .self_refresh_exit(self_refresh_exit), .cfg(cfg), .programmed(programmed),
      .dll_reset_pulse(dll_reset_pulse), .dll_locked(dll_locked), .read_ready(read_ready));
   dic_ctrl_model dic_ctrl_model_inst (.clk_sys(clk_sys), .cmd_pins(cmd_pins),
      .clk_en_pin(clk_en_pin));
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic finish_test();
      if (error_cnt == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // cfg lands four edges after the command and the pulse count five; issue ends three edges in, so three more edges reach six
   task automatic cmd(input logic [3:0] code, input logic [1:0] bs, input logic [12:0] a);
      dic_ctrl_model_inst.issue(code, bs, a);
      repeat (3) @(posedge clk_sys);
      #1;
   endtask
   task automatic wait_lock(output int n);
      n = 0;
      while (dll_locked !== 1'b1) begin
         @(posedge clk_sys);
         #1;
         n++;
         if (n > 400) begin
            chk("lock_wait", 24'h1, 24'h0);
            finish_test();
         end
      end
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_init();
      int t0, n;
      dic_cfg_t snap;
      chk("reset_prog", 24'h0, 24'(programmed));
      dic_ctrl_model_inst.power_up();
      cmd(4'h2, 2'h0, 13'h0400);
      cmd(4'h0, `DIC_SEL_EXT2, 13'h0080);
      chk("fast_sr", 24'h1, 24'(cfg.fast_self_refresh));
      cmd(4'h0, `DIC_SEL_EXT3, 13'h0000);
      cmd(4'h0, `DIC_SEL_EXT1, 13'h0000);
      chk("dll_en", 24'h1, 24'(cfg.dll_enabled));
      cmd(4'h0, `DIC_SEL_BASE, 13'h0b5b);
      t0 = cyc;
      chk("pulses", 24'h1, 24'(pulses));
      chk("base", 24'h1ed, 24'({cfg.burst_len, cfg.burst_interleave, cfg.read_latency,
         cfg.write_recovery}));
      chk("early_ready", 24'h0, 24'({dll_locked, read_ready}));
      snap = cfg;
      cmd(4'h2, 2'h0, 13'h0400);
      cmd(4'h1, 2'h0, 13'h0000);
      cmd(4'h1, 2'h0, 13'h0000);
      chk("cfg_hold", snap, cfg);
      cmd(4'h0, `DIC_SEL_BASE, 13'h0a5b);
      chk("no_reset", 24'h1, 24'(pulses));
      // calibration may only start once 200 clocks have passed since the dll reset
      wait_lock(n);
      chk("lock_clks", 24'h1, 24'(cyc - t0 >= 195 && cyc - t0 <= 202));
      cmd(4'h0, `DIC_SEL_EXT1, 13'h0796);
      chk("cal_dflt", 24'h7, 24'(cfg.driver_calibration));
      chk("ext1", 24'h53, 24'({cfg.reduced_drive, cfg.added_latency, cfg.termination_value,
         cfg.strobe_compl_off}));
      cmd(4'h0, `DIC_SEL_EXT1, 13'h0416);
      chk("cal_exit", 24'h0, 24'(cfg.driver_calibration));
      chk("ext1_keep", 24'h53, 24'({cfg.reduced_drive, cfg.added_latency,
         cfg.termination_value, cfg.strobe_compl_off}));
      chk("prog", 24'hf, 24'(programmed));
      chk("ready", 24'h1, 24'(read_ready));
   endtask
   task automatic t_mask();
      dic_cfg_t snap;
      snap = cfg;
      cmd(4'h8, `DIC_SEL_BASE, 13'h1fff);
      chk("cs_mask", snap, cfg);
      dic_ctrl_model_inst.set_cke(1'b0);
      cmd(4'h0, `DIC_SEL_BASE, 13'h1fff);
      chk("cke_mask", snap, cfg);
      dic_ctrl_model_inst.set_cke(1'b1);
      cmd(4'h0, `DIC_SEL_EXT3, 13'h1fff);
      chk("ext3_only", snap, cfg);
   endtask
   task automatic t_burst();
      for (int c = 0; c < 8; c++) begin
         cmd(4'h0, `DIC_SEL_BASE, {10'h14a, 3'(c)});
         chk("burst_len", 24'(c), 24'(cfg.burst_len));
         chk("bl_legal", 24'(3'(c) == `DIC_BL4 || 3'(c) == `DIC_BL8),
            24'(cfg.burst_len_legal));
      end
   endtask
   task automatic t_sr();
      int n, p;
      p = pulses;
      @(posedge clk_sys);
      self_refresh_enter <= 1'b1;
      repeat (4) @(posedge clk_sys);
      self_refresh_enter <= 1'b0;
      self_refresh_exit <= 1'b1;
      repeat (4) @(posedge clk_sys);
      self_refresh_exit <= 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
      chk("sr_restart", 24'(p + 1), 24'(pulses));
      chk("sr_ready", 24'h0, 24'(read_ready));
      wait_lock(n);
      chk("sr_relock", 24'h1, 24'(read_ready));
   endtask
   initial begin
      repeat (16) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      t_init();
      t_mask();
      t_burst();
      t_sr();
      finish_test();
   end
endmodule
